// ==== common/ptsf_pkg.sv ====
// Shared constants and types for the PTP time stamp calculator and queue
package ptsf_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_WORD0 = 8'h00;
    localparam logic [7:0] OFS_WORD1 = 8'h04;
    localparam logic [7:0] OFS_WORD6 = 8'h18;
    localparam logic [7:0] OFS_QCTRL = 8'h1C;
    localparam logic [7:0] OFS_LAT = 8'h20;
    localparam logic [7:0] OFS_PDLY = 8'h24;
    localparam logic [7:0] OFS_ASYM = 8'h28;
    localparam logic [7:0] OFS_CCTRL = 8'h2C;

    // Queue control register fields
    localparam int QC_SIG_LSB = 0;
    localparam int QC_SHORT_BIT = 5;
    localparam int QC_THEN_BIT = 6;
    localparam int QC_OCLR_BIT = 7;
    localparam int QC_THR_LSB = 8;
    localparam int QC_LVL_LSB = 16;
    localparam int QC_OVF_BIT = 24;

    // Calculator control register fields
    localparam int CC_ADD_BIT = 0;
    localparam int CC_SUB_BIT = 1;

    // First readout word fields
    localparam int W0_EMPTY_BIT = 31;
    localparam int W0_FLAG_LSB = 16;

    // Values after reset
    localparam logic [4:0] QC_SIG_RST = 5'h10;
    localparam logic [4:0] QC_THR_RST = 5'h08;
    localparam logic [31:0] LAT_RST = 32'h0000_0000;
    localparam logic [31:0] PDLY_RST = 32'h0000_0000;
    localparam logic [31:0] ASYM_RST = 32'h0000_0000;

    // Packing geometry and queue size
    localparam logic [5:0] LINE_BYTES = 6'h1A;
    localparam int LINE_BITS = 208;
    localparam logic [4:0] TS_BYTES = 5'h0A;
    localparam logic [4:0] TS_SHORT_BYTES = 5'h04;
    localparam logic [4:0] SIG_MAX_BYTES = 5'h10;
    localparam int Q_DEPTH = 16;
    localparam int Q_AW = 4;
    localparam int Q_LVLW = 5;
    localparam logic [2:0] FLG_FULL = 3'h7;

    // Nanoseconds in one second
    localparam logic [33:0] NS_PER_S = 34'h0_3B9A_CA00;

    // Command codes from the frame analyzer
    typedef enum logic [1:0] {
        PTSF_CMD_NONE = 2'b00,
        PTSF_CMD_STAMP = 2'b01,
        PTSF_CMD_CORR_ADD = 2'b10,
        PTSF_CMD_CORR_SUB = 2'b11
    } ptsf_cmd_t;

endpackage

// ==== src/ptsf_line_mem.sv ====
// Line storage for the packed time stamp queue, registered read port
`timescale 1ns/1ps
`default_nettype none

module ptsf_line_mem #(
    parameter int W = 211,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata_r
);

    logic [W-1:0] mem [DEPTH];

    // Storage array, no reset so it maps onto plain RAM
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read register follows the address every cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[raddr];
        end
    end

endmodule

`default_nettype wire

// ==== src/ptsf_stamp_calc.sv ====
// Time stamp and correction field arithmetic, one cycle of latency
`timescale 1ns/1ps
`default_nettype none

module ptsf_stamp_calc import ptsf_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Request from the analyzer
    input wire logic req,
    input wire logic egress,
    input wire logic is_event,
    input wire ptsf_cmd_t cmd,
    input wire logic [47:0] raw_sec,
    input wire logic [31:0] raw_ns,
    input wire logic [31:0] var_lat,
    input wire logic [63:0] corr_in,
    // Frozen settings
    input wire logic [31:0] lat,
    input wire logic [31:0] pdly,
    input wire logic [31:0] asym,
    input wire logic add_asym,
    input wire logic sub_asym,
    // Results
    output logic out_valid,
    output logic out_modify,
    output logic out_is_corr,
    output logic out_store,
    output logic [47:0] out_sec,
    output logic [31:0] out_ns,
    output logic [63:0] out_corr
);

    logic [32:0] tot;
    logic [33:0] ns_sum;
    logic [33:0] ns_dif;
    logic [47:0] act_sec;
    logic [31:0] act_ns;
    logic [63:0] act_ns64;
    logic [63:0] p2p_ns64;
    logic [63:0] asym_ext;
    logic [63:0] corr_c;

    // Active time, nanosecond field wraps into seconds
    always_comb begin
        tot = {1'b0, lat} + {1'b0, var_lat};
        ns_sum = {2'b00, raw_ns} + {1'b0, tot};
        ns_dif = {2'b00, raw_ns} - {1'b0, tot};
        act_sec = raw_sec;
        act_ns = raw_ns;
        if (egress) begin
            if (ns_sum >= NS_PER_S) begin
                act_ns = 32'(ns_sum - NS_PER_S);
                act_sec = raw_sec + 48'h1;
            end else begin
                act_ns = ns_sum[31:0];
            end
        end else if (ns_dif[33]) begin
            act_ns = 32'(ns_dif + NS_PER_S);
            act_sec = raw_sec - 48'h1;
        end else begin
            act_ns = ns_dif[31:0];
        end
    end

    // Flat nanoseconds and correction
    always_comb begin
        act_ns64 = 64'(act_sec) * 64'(NS_PER_S) + 64'(act_ns);
        p2p_ns64 = act_ns64 + 64'(pdly);
        asym_ext = {{32{asym[31]}}, asym};
        if (cmd == PTSF_CMD_CORR_ADD) begin
            corr_c = corr_in + {p2p_ns64[47:0], 16'h0000};
        end else begin
            corr_c = corr_in - {act_ns64[47:0], 16'h0000} + {16'h0000, pdly, 16'h0000};
        end
        if (add_asym) begin
            corr_c = corr_c + asym_ext;
        end
        if (sub_asym) begin
            corr_c = corr_c - asym_ext;
        end
    end

    // Result registers; non-event frames pass unmodified
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_modify <= 1'b0;
            out_is_corr <= 1'b0;
            out_store <= 1'b0;
            out_sec <= '0;
            out_ns <= '0;
            out_corr <= '0;
        end else begin
            out_valid <= req;
            out_modify <= req && is_event && (cmd != PTSF_CMD_NONE);
            out_is_corr <= cmd[1];
            out_store <= req && is_event && egress && (cmd != PTSF_CMD_NONE);
            out_sec <= act_sec;
            out_ns <= act_ns;
            out_corr <= corr_c;
        end
    end

endmodule

`default_nettype wire

// ==== src/ptsf_ts_engine.sv ====
// Time stamp calculator, signature packer and readout queue
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Output is a corrected time snapshot or a signed 64-bit correction.
// - Ingress active time is raw minus fixed latency minus variable latency.
// - Egress active time is raw plus fixed latency plus variable latency.
// - Derive active time in nanoseconds and that value plus path delay.
// - Path delay is always added into the produced correction field.
// - Asymmetry is a writable signed 32-bit value, low 16 bits sub-nanosecond.
// - Add-asymmetry control adds the sign-extended asymmetry to the correction.
// - Subtract-asymmetry control subtracts the sign-extended asymmetry from it.
// - Latency, path delay and asymmetry are shadowed against CPU writes.
// - Only event messages are modified, never follow-up messages.
// - Egress stamp predicts when the event frame leaves the chip.
// - Each stored entry raises an interrupt; overflow raises another one.
// - Only configured signature bytes are stored; entries pack together.
// - A full entry is 208 bits: 128 signature plus 80 stamp bits.
// - Zero signature gives 10-byte entries, or 4 bytes in short mode.
// - Packing register is written to the queue at 26 valid bytes.
// - Word 0 bit 31 is empty; otherwise word 0 holds 16 data bits.
// - Reading word 6 pops one queue line; software unpacks entries.
// - Draining to empty flushes a partly filled packing register.
// - Three flag bits tell where valid data ends in a line.
// - Maskable interrupt at threshold level; level readable by software.
// - Overflow inhibits writes and drops stamps; stored data stays readable.
module ptsf_ts_engine import ptsf_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Analyzer request
    input wire logic ts_req,
    input wire logic ts_egress,
    input wire logic ts_event,
    input wire ptsf_cmd_t ts_cmd,
    input wire logic [47:0] raw_sec,
    input wire logic [31:0] raw_ns,
    input wire logic [31:0] var_latency,
    input wire logic [63:0] corr_in,
    input wire logic [127:0] frame_sig,
    // Rewriter result
    output logic ts_valid,
    output logic ts_modify,
    output logic ts_is_corr,
    output logic [47:0] ts_sec,
    output logic [31:0] ts_ns,
    output logic [63:0] ts_corr,
    // Event outputs
    output logic irq_store,
    output logic irq_overflow,
    output logic irq_level
);

    ////////////////////////////////////////////////////////////////////////////////
    // Software settings

    logic [4:0] sig_len_r;
    logic short_r;
    logic thr_en_r;
    logic [4:0] thr_r;
    logic [31:0] lat_r;
    logic [31:0] pdly_r;
    logic [31:0] asym_r;
    logic add_asym_r;
    logic sub_asym_r;
    logic qctrl_wr;

    assign qctrl_wr = reg_wr && (reg_addr == OFS_QCTRL);

    // Writable registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sig_len_r <= QC_SIG_RST;
            short_r <= 1'b0;
            thr_en_r <= 1'b0;
            thr_r <= QC_THR_RST;
            lat_r <= LAT_RST;
            pdly_r <= PDLY_RST;
            asym_r <= ASYM_RST;
            add_asym_r <= 1'b0;
            sub_asym_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == OFS_QCTRL) begin
                sig_len_r <= reg_wdata[QC_SIG_LSB +: 5];
                short_r <= reg_wdata[QC_SHORT_BIT];
                thr_en_r <= reg_wdata[QC_THEN_BIT];
                thr_r <= reg_wdata[QC_THR_LSB +: 5];
            end else if (reg_addr == OFS_LAT) begin
                lat_r <= reg_wdata;
            end else if (reg_addr == OFS_PDLY) begin
                pdly_r <= reg_wdata;
            end else if (reg_addr == OFS_ASYM) begin
                asym_r <= reg_wdata;
            end else if (reg_addr == OFS_CCTRL) begin
                add_asym_r <= reg_wdata[CC_ADD_BIT];
                sub_asym_r <= reg_wdata[CC_SUB_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow copies and the calculator

    logic [31:0] lat_sh_r;
    logic [31:0] pdly_sh_r;
    logic [31:0] asym_sh_r;
    logic add_sh_r;
    logic sub_sh_r;

    // Shadows follow only while no request is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lat_sh_r <= LAT_RST;
            pdly_sh_r <= PDLY_RST;
            asym_sh_r <= ASYM_RST;
            add_sh_r <= 1'b0;
            sub_sh_r <= 1'b0;
        end else if (!ts_req) begin
            lat_sh_r <= lat_r;
            pdly_sh_r <= pdly_r;
            asym_sh_r <= asym_r;
            add_sh_r <= add_asym_r;
            sub_sh_r <= sub_asym_r;
        end
    end

    logic calc_store;

    ptsf_stamp_calc u_calc (
        .sys_clk(sys_clk),
        .srst(srst),
        .req(ts_req),
        .egress(ts_egress),
        .is_event(ts_event),
        .cmd(ts_cmd),
        .raw_sec(raw_sec),
        .raw_ns(raw_ns),
        .var_lat(var_latency),
        .corr_in(corr_in),
        .lat(lat_sh_r),
        .pdly(pdly_sh_r),
        .asym(asym_sh_r),
        .add_asym(add_sh_r),
        .sub_asym(sub_sh_r),
        .out_valid(ts_valid),
        .out_modify(ts_modify),
        .out_is_corr(ts_is_corr),
        .out_store(calc_store),
        .out_sec(ts_sec),
        .out_ns(ts_ns),
        .out_corr(ts_corr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Entry building and packing

    logic [4:0] sig_len_c;
    logic [4:0] ts_len;
    logic [5:0] ent_len;
    logic [127:0] sig_mask;
    logic [207:0] entry;
    logic [415:0] combined;
    logic [5:0] sum;
    logic [207:0] pack_r;
    logic [4:0] pack_cnt_r;
    logic [2:0] starts_r;

    // Entry is stamp bytes first, then the selected signature bytes
    always_comb begin
        sig_len_c = (sig_len_r > SIG_MAX_BYTES) ? SIG_MAX_BYTES : sig_len_r;
        ts_len = short_r ? TS_SHORT_BYTES : TS_BYTES;
        ent_len = {1'b0, ts_len} + {1'b0, sig_len_c};
        sig_mask = {128{1'b1}} >> (8'h80 - {sig_len_c, 3'b000});
        if (short_r) begin
            entry = {176'h0, ts_ns};
        end else begin
            entry = {128'h0, ts_sec, ts_ns};
        end
        entry = entry | ({80'h0, frame_sig & sig_mask} << {ts_len, 3'b000});
        combined = {208'h0, pack_r} | ({208'h0, entry} << {pack_cnt_r, 3'b000});
        sum = {1'b0, pack_cnt_r} + ent_len;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Queue control

    logic [Q_AW-1:0] wr_ptr_r;
    logic [Q_AW-1:0] rd_ptr_r;
    logic [Q_AW-1:0] rd_ptr_nxt;
    logic [Q_LVLW-1:0] count_r;
    logic full;
    logic ovf_r;
    logic avail_r;
    logic flush_arm_r;
    logic line_done;
    logic store_ok;
    logic drop;
    logic flush_go;
    logic push;
    logic pop;
    logic [210:0] push_data;
    logic [210:0] head;

    assign full = (count_r == Q_LVLW'(Q_DEPTH));
    assign line_done = (sum >= LINE_BYTES);
    // Drop while overflowed, or when a line meets a full queue
    assign drop = calc_store && (ovf_r || (line_done && full));
    assign store_ok = calc_store && !drop;
    assign flush_go = flush_arm_r && !calc_store && (pack_cnt_r != 5'h00) && !full;
    assign push = (store_ok && line_done) || flush_go;
    assign pop = reg_rd && (reg_addr == OFS_WORD6) && avail_r;
    assign rd_ptr_nxt = rd_ptr_r + Q_AW'(pop);

    // Line written: full line, or leftover bytes with start count
    always_comb begin
        if (flush_go) begin
            push_data = {starts_r, pack_r};
        end else begin
            push_data = {FLG_FULL, combined[207:0]};
        end
    end

    // Packing register and count of entries beginning in it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pack_r <= '0;
            pack_cnt_r <= '0;
            starts_r <= '0;
        end else if (store_ok && line_done) begin
            pack_r <= combined[415:208];
            pack_cnt_r <= 5'(sum - LINE_BYTES);
            starts_r <= '0;
        end else if (store_ok) begin
            pack_r <= combined[207:0];
            pack_cnt_r <= sum[4:0];
            starts_r <= starts_r + 3'h1;
        end else if (flush_go) begin
            pack_r <= '0;
            pack_cnt_r <= '0;
            starts_r <= '0;
        end
    end

    // Pointers and level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + Q_AW'(push);
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_r + Q_LVLW'(push) - Q_LVLW'(pop);
        end
    end

    // Head valid lags one cycle so the memory read register has caught up
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avail_r <= 1'b0;
        end else begin
            avail_r <= (count_r != '0) && !pop;
        end
    end

    // Arm a flush once reads drain the queue
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flush_arm_r <= 1'b0;
        end else if (pop && (count_r == Q_LVLW'(1)) && !push) begin
            flush_arm_r <= 1'b1;
        end else if (flush_go || (pack_cnt_r == 5'h00) || (count_r != '0)) begin
            flush_arm_r <= 1'b0;
        end
    end

    // Overflow latch; a new overflow wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ovf_r <= 1'b0;
        end else if (calc_store && line_done && full) begin
            ovf_r <= 1'b1;
        end else if (qctrl_wr && reg_wdata[QC_OCLR_BIT]) begin
            ovf_r <= 1'b0;
        end
    end

    ptsf_line_mem #(
        .W(211),
        .DEPTH(Q_DEPTH),
        .AW(Q_AW)
    ) u_mem (
        .sys_clk(sys_clk),
        .srst(srst),
        .we(push),
        .waddr(wr_ptr_r),
        .wdata(push_data),
        .raddr(rd_ptr_nxt),
        .rdata_r(head)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Event outputs

    // Registered so pulses line up with the stored state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_store <= 1'b0;
            irq_overflow <= 1'b0;
            irq_level <= 1'b0;
        end else begin
            irq_store <= store_ok;
            irq_overflow <= calc_store && line_done && full && !ovf_r;
            irq_level <= thr_en_r && (count_r >= thr_r) && (thr_r != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Readout

    logic [31:0] ro_word [7];
    logic [31:0] rdata_c;

    // First word: empty flag, end flags and 16 data bits
    assign ro_word[0] = avail_r ? {1'b0, 12'h000, head[210:208], head[15:0]}
                                : 32'h8000_0000;

    // Remaining words carry 32 data bits each
    genvar k;
    generate
        for (k = 1; k < 7; k++) begin : g_word
            assign ro_word[k] = avail_r ? head[32*k-16 +: 32] : 32'h0000_0000;
        end
    endgenerate

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        if (reg_addr <= OFS_WORD6 && reg_addr[1:0] == 2'b00) begin
            rdata_c = ro_word[reg_addr[4:2]];
        end else if (reg_addr == OFS_QCTRL) begin
            rdata_c = '0;
            rdata_c[QC_SIG_LSB +: 5] = sig_len_r;
            rdata_c[QC_SHORT_BIT] = short_r;
            rdata_c[QC_THEN_BIT] = thr_en_r;
            rdata_c[QC_THR_LSB +: 5] = thr_r;
            rdata_c[QC_LVL_LSB +: 5] = count_r;
            rdata_c[QC_OVF_BIT] = ovf_r;
        end else if (reg_addr == OFS_LAT) begin
            rdata_c = lat_r;
        end else if (reg_addr == OFS_PDLY) begin
            rdata_c = pdly_r;
        end else if (reg_addr == OFS_ASYM) begin
            rdata_c = asym_r;
        end else if (reg_addr == OFS_CCTRL) begin
            rdata_c = {30'h0, sub_asym_r, add_asym_r};
        end else begin
            rdata_c = '0;
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_c;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

`default_nettype wire

// ==== dv/ptsf_checker.sv ====
// Port checker for the time stamp engine
`timescale 1ns/1ps
`default_nettype none
module ptsf_chk import ptsf_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Analyzer side
    input wire logic ts_req,
    input wire logic ts_egress,
    input wire logic ts_event,
    input wire ptsf_cmd_t ts_cmd,
    // Results and events
    input wire logic ts_valid,
    input wire logic ts_modify,
    input wire logic ts_is_corr,
    input wire logic irq_store,
    input wire logic irq_overflow,
    input wire logic irq_level
);
default clocking @(posedge sys_clk); endclocking
default disable iff (srst);
logic [1:0] st_r;
// Storable requests, aligned to the store pulse
always_ff @(posedge sys_clk) begin
    st_r <= srst ? 2'b00 : {st_r[0], ts_req && ts_egress && ts_event && ts_cmd != PTSF_CMD_NONE};
end
property p_ans; ts_req |=> ts_valid; endproperty
a_ans: assert property (p_ans) else $error("result missing");
property p_cause; ts_valid |-> $past(ts_req); endproperty
a_cause: assert property (p_cause) else $error("result without request");
property p_mod; ts_valid |-> ts_modify == ($past(ts_event) && $past(ts_cmd) != PTSF_CMD_NONE);
endproperty
a_mod: assert property (p_mod) else $error("modify flag wrong");
property p_kind; ts_valid |-> ts_is_corr == ($past(ts_cmd) inside {PTSF_CMD_CORR_ADD,
    PTSF_CMD_CORR_SUB}); endproperty
a_kind: assert property (p_kind) else $error("result kind wrong");
property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
a_idle: assert property (p_idle) else $error("read data outside slot");
property p_unmap; reg_rd && reg_addr > OFS_CCTRL |=> reg_rdata == 32'h0; endproperty
a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
property p_store; irq_store |-> st_r[1]; endproperty
a_store: assert property (p_store) else $error("store pulse without stamp");
property p_ovf; irq_overflow |=> !irq_overflow [*4]; endproperty
a_ovf: assert property (p_ovf) else $error("overflow pulse too long");
c_store: cover property (irq_store);
c_ovf: cover property (irq_overflow);
c_lvl: cover property (irq_level);
endmodule
bind ptsf_ts_engine ptsf_chk u_chk (.sys_clk, .srst, .reg_addr, .reg_rd, .reg_rdata, .ts_req,
    .ts_egress, .ts_event, .ts_cmd, .ts_valid, .ts_modify, .ts_is_corr, .irq_store,
    .irq_overflow, .irq_level);
`default_nettype wire

// ==== dv/tb_ptsf_ts_engine.sv ====
// Self-checking bench for the time stamp engine
`timescale 1ns/1ps
`default_nettype none
module tb_ptsf_ts_engine import ptsf_pkg::*;;
    logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ts_req = 1'b0;
    logic ts_egress = 1'b0, ts_event = 1'b0, ts_valid, ts_modify, ts_is_corr;
    logic irq_store, irq_overflow, irq_level, rd_seen = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, raw_ns = 32'h0, var_latency = 32'h0, reg_rdata, ts_ns;
    ptsf_cmd_t ts_cmd = PTSF_CMD_NONE;
    logic [47:0] raw_sec = 48'h0, ts_sec;
    logic [63:0] corr_in = 64'h0, ts_corr;
    logic [127:0] frame_sig = 128'h0;
    logic [145:0] tq_v[$], tq_m[$];
    logic [31:0] rq_v[$], rq_m[$], nsv[0:6];
    int failures = 0, n_compared = 0, cyc = 0, n_store = 0, n_ovf = 0;
    ptsf_ts_engine dut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ts_req, .ts_egress, .ts_event, .ts_cmd, .raw_sec, .raw_ns, .var_latency, .corr_in,
        .frame_sig, .ts_valid, .ts_modify, .ts_is_corr, .ts_sec, .ts_ns, .ts_corr, .irq_store,
        .irq_overflow, .irq_level);
    initial forever #50 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [145:0] got, input logic [145:0] exp, input logic [145:0] m);
        n_compared++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got & m, exp & m);
        end
    endtask
    // An idle edge ends each strobe task
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq_v.push_back(e);
        rq_m.push_back(m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic req(input logic [145:0] e, input logic [145:0] m);
        tq_v.push_back(e);
        tq_m.push_back(m);
        ts_req <= 1'b1;
        @(posedge sys_clk);
        ts_req <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Egress stamp, zero latency: stamp equals raw time
    task automatic stamp(input logic [31:0] n);
        ts_egress <= 1'b1;
        ts_event <= 1'b1;
        ts_cmd <= PTSF_CMD_STAMP;
        raw_sec <= 48'h0;
        raw_ns <= n;
        var_latency <= 32'h0;
        req({2'b10, 48'h0, n, 64'h0}, {2'b11, {80{1'b1}}, 64'h0});
    endtask
    task automatic wrap_up();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: oldest note per result; ceiling far above the run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
        if (!srst && rd_seen) begin
            chk(146'(reg_rdata), 146'(rq_v.pop_front()), 146'(rq_m.pop_front()));
        end
        if (!srst && ts_valid === 1'b1) begin
            chk({ts_modify, ts_is_corr, ts_sec, ts_ns, ts_corr}, tq_v.pop_front(),
                tq_m.pop_front());
        end
        n_store <= srst ? 0 : n_store + int'(irq_store === 1'b1);
        n_ovf <= n_ovf + int'(irq_overflow === 1'b1);
        rd_seen <= reg_rd;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [47:0] s;
        logic [31:0] n, an_ns, vl, lat, pd, asy;
        logic [1:0] c;
        logic [63:0] an, ce, corr;
        void'($urandom(32'hC0F4));
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        lat = $urandom_range(1000000);
        pd = $urandom;
        asy = $urandom;
        wr(OFS_LAT, lat);
        wr(OFS_PDLY, pd);
        wr(OFS_ASYM, asy);
        // Both directions, all commands, add and subtract asymmetry, a follow-up
        for (int i = 0; i < 17; i++) begin
            vl = $urandom_range(1000000);
            c = i[2:1] | {1'b0, i[4]};
            s = 48'($urandom_range(65535));
            n = 2000000 + $urandom_range(900000000);
            an_ns = i[0] ? n + lat + vl : n - lat - vl;
            an = 64'(s) * 64'h3B9A_CA00 + 64'(an_ns);
            ce = {$urandom, $urandom};
            corr = c == 2'h2 ? ce + ((an + pd) << 16) : ce - (an << 16) + (64'(pd) << 16);
            corr = i[3] ? corr - {{32{asy[31]}}, asy} : corr + {{32{asy[31]}}, asy};
            wr(OFS_CCTRL, i[3] ? 32'h2 : 32'h1);
            ts_egress <= i[0];
            ts_event <= !i[4];
            ts_cmd <= ptsf_cmd_t'(c);
            raw_sec <= s;
            raw_ns <= n;
            var_latency <= vl;
            corr_in <= ce;
            frame_sig <= {$urandom, $urandom, $urandom, $urandom};
            req({!i[4] && c != 2'h0, c[1], s, an_ns, corr}, {2'b11, {80{1'b1}}, {64{c[1]}}});
        end
        $display("calc test done");
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd(OFS_QCTRL, 32'h0000_0810, 32'h011F_1F7F);
        rd(8'hF0, 32'h0, 32'hFFFF_FFFF);
        rd(OFS_WORD0, 32'h8000_0000, 32'h8000_0000);
        wr(OFS_QCTRL, 32'h0000_0020);
        // Seven short entries: one line plus two bytes left over
        for (int k = 0; k < 7; k++) begin
            nsv[k] = $urandom_range(999999999);
            stamp(nsv[k]);
        end
        repeat (3) @(posedge sys_clk);
        rd(OFS_WORD0, {13'h0, 3'h7, nsv[0][15:0]}, 32'h8007_FFFF);
        rd(OFS_WORD1, {nsv[1][15:0], nsv[0][31:16]}, 32'hFFFF_FFFF);
        rd(OFS_WORD6, {nsv[6][15:0], nsv[5][31:16]}, 32'hFFFF_FFFF);
        repeat (3) @(posedge sys_clk);
        rd(OFS_WORD0, {13'h0, 3'h0, nsv[6][31:16]}, 32'h8007_FFFF);
        rd(OFS_WORD6, 32'h0, 32'h0);
        rd(OFS_WORD0, 32'h8000_0000, 32'h8000_0000);
        chk(146'(n_store), 146'h7, {146{1'b1}});
        $display("packing test done");
        // Fill sixteen lines, then one more
        wr(OFS_QCTRL, 32'h0000_0260);
        for (int k = 0; k < 104; k++) stamp($urandom_range(999999999));
        repeat (3) @(posedge sys_clk);
        rd(OFS_QCTRL, 32'h0010_0260, 32'h011F_1F7F);
        chk(146'(irq_level), 146'h1, 146'h1);
        for (int k = 0; k < 7; k++) stamp(32'h0);
        repeat (3) @(posedge sys_clk);
        chk(146'(n_ovf), 146'h1, {146{1'b1}});
        rd(OFS_QCTRL, 32'h0110_0260, 32'h011F_1F7F);
        rd(OFS_WORD0, 32'h0007_0000, 32'h8007_0000);
        wr(OFS_QCTRL, 32'h0000_00A0);
        rd(OFS_QCTRL, 32'h0010_0020, 32'h011F_1F7F);
        chk(146'(irq_level), 146'h0, 146'h1);
        $display("overflow test done");
        wrap_up();
    end
endmodule
`default_nettype wire
